//--- core/axrs_slave.sv
// RAM-side AXI4 slave: read address, read data and write response channels
//
// How it works
// - Write response code is always OKAY
// - Response code only with memory profile IDs
// - Slave drives BVALID, master drives BREADY
// - Read ID optional, one to 16 bits
// - Only burst start address taken; rest computed
// - Length field plus one beats returned exactly
// - Master never asks size wider than bus
// - Memory profile accepts incrementing or wrapping bursts
// - Register profile treats every burst as incrementing
// - Master holds address stable until ARREADY
// - ARREADY high only when address can be taken
// - Read ID echoes the address ID
// - Read data width set by parameter
// - Read response always OKAY, memory profile only
// - RLAST on final beat only
// - RVALID high only while read data present
// - Master drives RREADY when it takes data
// - Write response ID echoes write address ID
`timescale 1ns/1ps
module axrs_slave
    import axrs_pkg::*;
#(
    parameter int DATA_W = AXRS_DATA_W_DEF,     // 32..256, or 8..256 register style
    parameter int ID_W = AXRS_ID_W_DEF,         // 1..16
    parameter bit MEM_PROFILE = 1'b1,           // 1 memory profile, 0 register style
    parameter bit ID_EN = 1'b1,                 // IDs and response codes present, memory profile only
    parameter int FIFO_DEPTH = AXRS_FIFO_DEPTH  // Read data buffer depth
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Bus side
    axrs_if.dev bus,
    // RAM read port, data one cycle after the enable
    output logic mem_en,
    output logic [AXRS_ADDR_W-1:0] mem_addr,
    input wire logic [DATA_W-1:0] mem_rdata,
    // Write completion from the write path
    input wire logic wr_done_valid,
    input wire logic [ID_W-1:0] wr_done_id,
    output logic wr_done_ready
);
    // *********************************************
    // Derived constants
    // *********************************************
    localparam int LW = $clog2(FIFO_DEPTH+1);
    localparam int FW = ID_W + 1 + DATA_W;     // Buffer entry: id, last, data
    localparam bit IDS_ON = MEM_PROFILE && ID_EN;
    // Full bus width as a size code
    localparam logic [AXRS_SIZE_W-1:0] BUS_SIZE = AXRS_SIZE_W'($clog2(DATA_W/8));

    typedef enum logic [0:0] {AXRS_IDLE, AXRS_BURST} axrs_state_t;

    // *********************************************
    // Burst state
    // *********************************************
    axrs_state_t state_reg;                    // Idle or walking a burst
    axrs_state_t state_next;
    logic [AXRS_ADDR_W-1:0] addr_reg;          // Address of next beat
    logic [AXRS_ADDR_W-1:0] addr_next;
    logic [AXRS_ADDR_W-1:0] wrap_mask_reg;     // Total burst bytes minus one
    logic [AXRS_LEN_W-1:0] left_reg;           // Beats left after this one
    logic [AXRS_SIZE_W-1:0] size_reg;          // Bytes per beat as a code
    logic [1:0] burst_reg;                     // Type in effect for the burst
    logic [ID_W-1:0] id_reg;                   // ID of the burst in flight
    // RAM read in flight
    logic pend_reg;                            // RAM data arrives this cycle
    logic pend_last_reg;                       // That beat ends the burst
    logic [ID_W-1:0] pend_id_reg;              // That beat's ID
    // Write response
    logic bvalid_reg;
    logic [ID_W-1:0] bid_reg;

    // *********************************************
    // Request decode
    // *********************************************
    wire ar_take;                              // Address handshake this cycle
    wire [AXRS_SIZE_W-1:0] req_size;
    wire [1:0] req_burst;
    wire [ID_W-1:0] req_id;
    wire [AXRS_ADDR_W-1:0] req_total;          // Bytes in the whole burst
    wire room;                                 // Buffer has space counting flight
    wire issue;                                // Read one beat from the RAM
    wire last_beat;
    wire [LW-1:0] fifo_level;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [FW-1:0] fifo_out_data;

    // Only idle accepts an address, so control is sampled exactly once
    assign bus.arready = (state_reg == AXRS_IDLE);
    assign ar_take = bus.arvalid && bus.arready;
    // Size absent in register style: beats use the full bus width
    assign req_size = MEM_PROFILE ? bus.arsize : BUS_SIZE;
    // Register style has no type input and always increments
    assign req_burst = MEM_PROFILE ? bus.arburst : AXRS_BURST_INCR;
    assign req_id = IDS_ON ? bus.arid : '0;
    // Wrap window is length field plus one, times beat size
    assign req_total = ({24'h0, bus.arlen} + 32'h1) << req_size;

    // One RAM read may be in flight, so leave room for it before issuing
    assign room = (32'(fifo_level) + 32'(pend_reg)) < 32'(FIFO_DEPTH);
    assign issue = (state_reg == AXRS_BURST) && room && fifo_in_ready;
    assign last_beat = (left_reg == '0);
    assign mem_en = issue;
    assign mem_addr = addr_reg;

    // *********************************************
    // Next address
    // *********************************************
    wire [AXRS_ADDR_W-1:0] beat_bytes;
    wire [AXRS_ADDR_W-1:0] aligned;
    wire [AXRS_ADDR_W-1:0] incr_addr;
    wire [AXRS_ADDR_W-1:0] wrap_addr;

    assign beat_bytes = 32'h1 << size_reg;
    // After the first beat every address is size aligned
    assign aligned = addr_reg & ~(beat_bytes - 32'h1);
    assign incr_addr = aligned + beat_bytes;
    // Stay inside the window, folding back to its base at the top
    assign wrap_addr = (addr_reg & ~wrap_mask_reg) | (incr_addr & wrap_mask_reg);
    // Fixed code is not a supported type here and is walked as incrementing
    assign addr_next = (burst_reg == AXRS_BURST_WRAP) ? wrap_addr : incr_addr;

    // Burst sequencing
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            AXRS_IDLE: begin
                if (ar_take) begin
                    state_next = AXRS_BURST;
                end
            end
            AXRS_BURST: begin
                // Exactly length plus one beats, then free for the next address
                if (issue && last_beat) begin
                    state_next = AXRS_IDLE;
                end
            end
            default: begin
                state_next = AXRS_IDLE;
            end
        endcase
    end

    // Burst registers load on the handshake and step on each issued beat
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= AXRS_IDLE;
            addr_reg <= '0;
            wrap_mask_reg <= '0;
            left_reg <= '0;
            size_reg <= '0;
            burst_reg <= AXRS_BURST_INCR;
            id_reg <= '0;
        end else begin
            state_reg <= state_next;
            if (ar_take) begin
                addr_reg <= bus.araddr;
                wrap_mask_reg <= req_total - 32'h1;
                left_reg <= bus.arlen;
                size_reg <= req_size;
                burst_reg <= req_burst;
                id_reg <= req_id;
            end else if (issue) begin
                addr_reg <= addr_next;
                left_reg <= left_reg - 8'h1;
            end
        end
    end

    // Tag the RAM read so its data lands in the buffer with id and last
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_reg <= 1'b0;
            pend_last_reg <= 1'b0;
            pend_id_reg <= '0;
        end else begin
            pend_reg <= issue;
            pend_last_reg <= issue && last_beat;
            pend_id_reg <= id_reg;
        end
    end

    // *********************************************
    // Read data buffer
    // *********************************************
    // Space was reserved at issue, so the push never meets a full buffer
    axrs_fifo #(
        .W(FW),
        .DEPTH(FIFO_DEPTH)
    ) u_rbuf (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(pend_reg),
        .in_ready(fifo_in_ready),
        .in_data({pend_id_reg, pend_last_reg, mem_rdata}),
        .out_valid(fifo_out_valid),
        .out_ready(bus.rready),
        .out_data(fifo_out_data),
        .level(fifo_level)
    );

    // Buffer head holds still until taken, so the beat stays stable
    assign bus.rvalid = fifo_out_valid;
    assign bus.rdata = fifo_out_data[DATA_W-1:0];
    assign bus.rlast = fifo_out_data[DATA_W];
    assign bus.rid = IDS_ON ? fifo_out_data[FW-1:DATA_W+1] : '0;
    // Without IDs the response is not provided and reads as zero
    assign bus.rresp = AXRS_RESP_OKAY;

    // *********************************************
    // Write response
    // *********************************************
    // A new completion is taken when the slot is empty or being emptied
    assign wr_done_ready = !bvalid_reg || bus.bready;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bvalid_reg <= 1'b0;
            bid_reg <= '0;
        end else begin
            if (wr_done_valid && wr_done_ready) begin
                bvalid_reg <= 1'b1;
                bid_reg <= IDS_ON ? wr_done_id : '0;
            end else if (bus.bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    assign bus.bvalid = bvalid_reg;
    assign bus.bid = bid_reg;
    // Never an error code; absent without IDs, so it stays at zero
    assign bus.bresp = AXRS_RESP_OKAY;
endmodule // axrs_slave

//--- core/axrs_pkg.sv
// Shared constants for the AXI4 RAM slave read path and write response
package axrs_pkg;
    // *********************************************
    // Bus geometry
    // *********************************************
    localparam int AXRS_ADDR_W = 32;       // Read address width
    localparam int AXRS_LEN_W = 8;         // Burst length field width
    localparam int AXRS_SIZE_W = 3;        // Transfer size field width
    localparam int AXRS_ID_W_DEF = 4;      // Default ID width, 1 to 16 allowed
    localparam int AXRS_ID_W_MAX = 16;     // Widest ID the block accepts
    localparam int AXRS_DATA_W_DEF = 32;   // Default read data width
    localparam int AXRS_FIFO_DEPTH = 32;   // Read data buffer depth in beats

    // *********************************************
    // Encodings
    // *********************************************
    localparam logic [1:0] AXRS_RESP_OKAY = 2'h0;    // Normal access done
    localparam logic [1:0] AXRS_BURST_FIXED = 2'h0;  // Fixed address burst
    localparam logic [1:0] AXRS_BURST_INCR = 2'h1;   // Incrementing burst
    localparam logic [1:0] AXRS_BURST_WRAP = 2'h2;   // Wrapping burst
endpackage

//--- core/axrs_if.sv
// Read address, read data and write response channels between master and slave
`timescale 1ns/1ps
interface axrs_if #(
    parameter int ID_W = 4,
    parameter int DATA_W = 32
);
    // Read address channel
    logic [ID_W-1:0] arid;
    logic [31:0] araddr;
    logic [7:0] arlen;
    logic [2:0] arsize;
    logic [1:0] arburst;
    logic arvalid;
    logic arready;
    // Read data channel
    logic [ID_W-1:0] rid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
    logic rlast;
    logic rvalid;
    logic rready;
    // Write response channel
    logic [ID_W-1:0] bid;
    logic [1:0] bresp;
    logic bvalid;
    logic bready;

    // Memory side end
    modport dev (
        input arid, araddr, arlen, arsize, arburst, arvalid, rready, bready,
        output arready, rid, rdata, rresp, rlast, rvalid, bid, bresp, bvalid
    );
    // Bus master end
    modport mst (
        output arid, araddr, arlen, arsize, arburst, arvalid, rready, bready,
        input arready, rid, rdata, rresp, rlast, rvalid, bid, bresp, bvalid
    );
endinterface

//--- core/axrs_fifo.sv
// Flip-flop FIFO with valid and ready on both sides and a fill level
`timescale 1ns/1ps
module axrs_fifo #(
    parameter int W = 32,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data,
    // Entries held
    output logic [$clog2(DEPTH+1)-1:0] level
);
    localparam int PW = $clog2(DEPTH);
    localparam int LW = $clog2(DEPTH+1);

    logic [W-1:0] store_reg [DEPTH];   // Entries, no reset needed
    logic [PW-1:0] wr_ptr_reg;         // Next slot to fill
    logic [PW-1:0] rd_ptr_reg;         // Oldest slot
    logic [LW-1:0] level_reg;          // Number of entries held
    logic push;
    logic pop;

    // *********************************************
    // Handshakes
    // *********************************************
    assign in_ready = (level_reg != LW'(DEPTH));
    assign out_valid = (level_reg != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = store_reg[rd_ptr_reg];
    assign level = level_reg;

    // Storage, one write port per entry
    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
        always_ff @(posedge clk) begin
            if (push && wr_ptr_reg == PW'(i)) begin
                store_reg[i] <= in_data;
            end
        end
    end

    // Pointers wrap back to zero after slot DEPTH-1, so the depth need not be a power of two
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            level_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            level_reg <= level_reg + LW'(push) - LW'(pop);
        end
    end
endmodule // axrs_fifo

//--- core/axrs_master.sv
// Bus master end: issues read bursts and collects read data and write responses
`timescale 1ns/1ps
module axrs_master
    import axrs_pkg::*;
#(
    parameter int DATA_W = AXRS_DATA_W_DEF,
    parameter int ID_W = AXRS_ID_W_DEF
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Bus side
    axrs_if.mst bus,
    // Read command from the user
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [ID_W-1:0] cmd_id,
    input wire logic [AXRS_ADDR_W-1:0] cmd_addr,
    input wire logic [AXRS_LEN_W-1:0] cmd_len,
    input wire logic [AXRS_SIZE_W-1:0] cmd_size,
    input wire logic [1:0] cmd_burst,
    // Read beats to the user
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [DATA_W-1:0] rd_data,
    output logic [ID_W-1:0] rd_id,
    output logic rd_last,
    output logic [1:0] rd_resp,
    // Write responses to the user
    output logic wr_resp_valid,
    input wire logic wr_resp_ready,
    output logic [ID_W-1:0] wr_resp_id,
    output logic [1:0] wr_resp_code
);
    localparam logic [AXRS_SIZE_W-1:0] BUS_SIZE = AXRS_SIZE_W'($clog2(DATA_W/8));

    logic arvalid_reg;
    logic rvalid_reg;
    logic bvalid_reg;
    wire cmd_take;
    wire r_take;
    wire b_take;

    // *********************************************
    // Read address
    // *********************************************
    // Registered channel: address and control stay put until ARREADY
    assign cmd_ready = !arvalid_reg || bus.arready;
    assign cmd_take = cmd_valid && cmd_ready;
    assign bus.arvalid = arvalid_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            arvalid_reg <= 1'b0;
            bus.arid <= '0;
            bus.araddr <= '0;
            bus.arlen <= '0;
            bus.arsize <= '0;
            bus.arburst <= AXRS_BURST_INCR;
        end else if (cmd_take) begin
            arvalid_reg <= 1'b1;
            bus.arid <= cmd_id;
            bus.araddr <= cmd_addr;
            bus.arlen <= cmd_len;
            // Clamp so no beat is wider than the data bus
            bus.arsize <= (cmd_size > BUS_SIZE) ? BUS_SIZE : cmd_size;
            bus.arburst <= cmd_burst;
        end else if (bus.arready) begin
            arvalid_reg <= 1'b0;
        end
    end

    // *********************************************
    // Read data and write response
    // *********************************************
    // One-deep output stage; ready only while it can take a beat
    assign bus.rready = !rvalid_reg || rd_ready;
    assign r_take = bus.rvalid && bus.rready;
    assign bus.bready = !bvalid_reg || wr_resp_ready;
    assign b_take = bus.bvalid && bus.bready;
    assign rd_valid = rvalid_reg;
    assign wr_resp_valid = bvalid_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rvalid_reg <= 1'b0;
            rd_data <= '0;
            rd_id <= '0;
            rd_last <= 1'b0;
            rd_resp <= AXRS_RESP_OKAY;
        end else if (r_take) begin
            rvalid_reg <= 1'b1;
            rd_data <= bus.rdata;
            rd_id <= bus.rid;
            rd_last <= bus.rlast;
            rd_resp <= bus.rresp;
        end else if (rd_ready) begin
            rvalid_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bvalid_reg <= 1'b0;
            wr_resp_id <= '0;
            wr_resp_code <= AXRS_RESP_OKAY;
        end else if (b_take) begin
            bvalid_reg <= 1'b1;
            wr_resp_id <= bus.bid;
            wr_resp_code <= bus.bresp;
        end else if (wr_resp_ready) begin
            bvalid_reg <= 1'b0;
        end
    end
endmodule // axrs_master

//--- bench/axrs_chk.sv
// Concurrent checks on the read and write response channels
`timescale 1ns/1ps
module axrs_chk
    import axrs_pkg::*;
#(
    parameter int ID_W = 4,
    parameter int DATA_W = 32
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Read address channel
    input wire logic [ID_W-1:0] arid,
    input wire logic [31:0] araddr,
    input wire logic [7:0] arlen,
    input wire logic arvalid,
    input wire logic arready,
    // Read data channel
    input wire logic [ID_W-1:0] rid,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rlast,
    input wire logic rvalid,
    input wire logic rready,
    // Write response channel
    input wire logic [ID_W-1:0] bid,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready
);
    // *********************************************
    // Beat counter inside the current burst
    // *********************************************
    logic [8:0] beat_cnt_reg; // Beats taken since the last final beat
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            beat_cnt_reg <= 9'h000;
        end else if (rvalid && rready) begin
            beat_cnt_reg <= rlast ? 9'h000 : beat_cnt_reg + 9'h001;
        end
    end

    // *********************************************
    // Assertions
    // *********************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_bresp_okay: assert property (bvalid |-> bresp == AXRS_RESP_OKAY)
        else $error("write response code not OKAY");
    a_rresp_okay: assert property (rvalid |-> rresp == AXRS_RESP_OKAY)
        else $error("read response code not OKAY");
    a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bid))
        else $error("write response dropped or changed");
    a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata)
        && $stable(rlast) && $stable(rid))
        else $error("read beat dropped or changed");
    a_ar_hold: assert property (arvalid && !arready |=> arvalid && $stable(araddr)
        && $stable(arlen) && $stable(arid))
        else $error("read address dropped or changed");
    a_ar_busy: assert property (arvalid && arready |=> !arready)
        else $error("address taken during a burst");
    a_first_beat: assert property (arvalid && arready && !rvalid |-> ##[1:3] rvalid)
        else $error("first read beat late");
    a_rid_burst: assert property (rvalid && rready && !rlast |=> !rvalid || $stable(rid))
        else $error("read id changed inside a burst");
    a_burst_max: assert property (rvalid && rready && !rlast |-> beat_cnt_reg < 9'h0FF)
        else $error("burst ran past 256 beats");
endmodule // axrs_chk

//--- bench/tb.sv
// Bench: master and slave ends joined across the bus interface
`timescale 1ns/1ps
module tb
    import axrs_pkg::*;
;
    // *********************************************
    // Signals
    // *********************************************
    logic clk = 1'b0; // 250 MHz
    logic rst_n = 1'b0; // Asynchronous, active low
    int fails = 0; // Mismatches seen
    int n_checks = 0; // Comparisons made
    logic cmd_valid = 1'b0, cmd_ready; // Read command handshake
    logic [3:0] cmd_id;
    logic [31:0] cmd_addr;
    logic [7:0] cmd_len;
    logic [2:0] cmd_size;
    logic [1:0] cmd_burst;
    logic rd_valid, rd_last, rd_ready = 1'b1; // Read beats to the user
    logic [31:0] rd_data;
    logic [3:0] rd_id, wr_resp_id, wr_done_id;
    logic [1:0] rd_resp, wr_resp_code;
    logic wr_resp_valid, wr_resp_ready = 1'b1; // Write responses to the user
    logic wr_done_valid = 1'b0, wr_done_ready; // Completions from the write path
    logic mem_en; // RAM read port
    logic [31:0] mem_addr, mem_rdata;

    always #2 clk = ~clk;

    // RAM model: one cycle latency, reads on the enable only
    function automatic logic [31:0] ram_word(logic [31:0] a);
        return {a[15:0], ~a[15:0]};
    endfunction
    always @(posedge clk) if (mem_en) mem_rdata <= #1 ram_word(mem_addr);

    // *********************************************
    // Design ends, interface and checker
    // *********************************************
    axrs_if #(.ID_W(4), .DATA_W(32)) bus ();
    axrs_slave i_axrs_slave (.clk(clk), .rst_n(rst_n), .bus(bus), .mem_en(mem_en),
        .mem_addr(mem_addr), .mem_rdata(mem_rdata), .wr_done_valid(wr_done_valid),
        .wr_done_id(wr_done_id), .wr_done_ready(wr_done_ready));
    axrs_master i_axrs_master (.clk(clk), .rst_n(rst_n), .bus(bus), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_id(cmd_id), .cmd_addr(cmd_addr), .cmd_len(cmd_len),
        .cmd_size(cmd_size), .cmd_burst(cmd_burst), .rd_valid(rd_valid), .rd_ready(rd_ready),
        .rd_data(rd_data), .rd_id(rd_id), .rd_last(rd_last), .rd_resp(rd_resp),
        .wr_resp_valid(wr_resp_valid), .wr_resp_ready(wr_resp_ready),
        .wr_resp_id(wr_resp_id), .wr_resp_code(wr_resp_code));
    axrs_chk #(.ID_W(4), .DATA_W(32)) i_axrs_chk (.clk(clk), .rst_n(rst_n), .arid(bus.arid),
        .araddr(bus.araddr), .arlen(bus.arlen), .arvalid(bus.arvalid), .arready(bus.arready),
        .rid(bus.rid), .rdata(bus.rdata), .rresp(bus.rresp), .rlast(bus.rlast),
        .rvalid(bus.rvalid), .rready(bus.rready), .bid(bus.bid), .bresp(bus.bresp),
        .bvalid(bus.bvalid), .bready(bus.bready));

    // *********************************************
    // Shared tasks
    // *********************************************
    // One clock, then the input delay; a hang ends at the watchdog
    task automatic tick;
        @(posedge clk);
        #1;
    endtask

    task automatic check(logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Expected next beat address, aligned step with wrap window
    function automatic logic [31:0] next_addr(logic [31:0] a, logic [2:0] sz, logic [7:0] len,
        logic [1:0] bt);
        logic [31:0] step, inc, mask;
        step = 32'h1 << sz;
        inc = (a & ~(step - 32'h1)) + step;
        mask = (({24'h0, len} + 32'h1) << sz) - 32'h1;
        return (bt == AXRS_BURST_WRAP) ? ((a & ~mask) | (inc & mask)) : inc;
    endfunction

    // Leaves valid high so a second command can follow at once
    task automatic send_cmd(logic [3:0] id, logic [31:0] a, logic [7:0] len, logic [2:0] sz,
        logic [1:0] bt);
        cmd_valid = 1'b1;
        cmd_id = id;
        cmd_addr = a;
        cmd_len = len;
        cmd_size = sz;
        cmd_burst = bt;
        while (cmd_ready !== 1'b1) tick();
        tick();
    endtask

    task automatic get_burst(logic [3:0] id, logic [31:0] a, logic [7:0] len, logic [2:0] sz,
        logic [1:0] bt);
        for (int b = 0; b <= int'(len); b++) begin
            while (rd_valid !== 1'b1) tick();
            check(rd_data, ram_word(a));
            check(32'(rd_id), 32'(id));
            check(32'(rd_last), 32'(b == int'(len)));
            check(32'(rd_resp), 32'(AXRS_RESP_OKAY));
            a = next_addr(a, sz, len, bt);
            tick();
        end
    endtask

    task automatic read1(logic [3:0] id, logic [31:0] a, logic [7:0] len, logic [2:0] sz,
        logic [1:0] bt);
        send_cmd(id, a, len, sz, bt);
        cmd_valid = 1'b0;
        get_burst(id, a, len, sz, bt);
    endtask

    // *********************************************
    // Scenarios
    // *********************************************
    task automatic t_idle;
        check(32'(bus.arready), 32'h1);
        check(32'(bus.rvalid), 32'h0);
        check(32'(bus.bvalid), 32'h0);
        $display("test idle done");
    endtask

    // Every legal size, shortest and longest burst lengths
    task automatic t_incr;
        logic [7:0] lens [3] = '{8'h00, 8'h05, 8'hFF};
        for (int s = 0; s < 3; s++) begin
            read1(4'(s + 1), 32'h0000_1000 + 32'(s) * 32'h400, lens[s], 3'(s), AXRS_BURST_INCR);
        end
        $display("test incr done");
    endtask

    // Start in mid window so the address must fold back
    task automatic t_wrap;
        read1(4'h5, 32'h0000_2008, 8'h03, 3'h2, AXRS_BURST_WRAP);
        read1(4'h6, 32'h0000_300A, 8'h07, 3'h1, AXRS_BURST_WRAP);
        $display("test wrap done");
    endtask

    // Two bursts with different ids issued back to back
    task automatic t_b2b;
        fork
            begin
                send_cmd(4'hA, 32'h0000_4000, 8'h02, 3'h2, AXRS_BURST_INCR);
                send_cmd(4'hB, 32'h0000_5000, 8'h01, 3'h2, AXRS_BURST_WRAP);
                cmd_valid = 1'b0;
            end
            begin
                get_burst(4'hA, 32'h0000_4000, 8'h02, 3'h2, AXRS_BURST_INCR);
                get_burst(4'hB, 32'h0000_5000, 8'h01, 3'h2, AXRS_BURST_WRAP);
            end
        join
        $display("test back to back done");
    endtask

    // User stalls until the buffer refuses, then drains it empty
    task automatic t_stall;
        rd_ready = 1'b0;
        send_cmd(4'h7, 32'h0000_6000, 8'h3F, 3'h2, AXRS_BURST_INCR);
        cmd_valid = 1'b0;
        repeat (80) tick();
        check(32'(bus.arready), 32'h0);
        check(32'(bus.rvalid), 32'h1);
        rd_ready = 1'b1;
        get_burst(4'h7, 32'h0000_6000, 8'h3F, 3'h2, AXRS_BURST_INCR);
        $display("test stall done");
    endtask

    // Three completions, the third refused while the user stalls
    task automatic t_wresp;
        wr_resp_ready = 1'b0;
        wr_done_valid = 1'b1;
        wr_done_id = 4'h9;
        tick();
        wr_done_id = 4'hA;
        tick();
        wr_done_id = 4'hB;
        check(32'(wr_done_ready), 32'h0);
        check(32'(bus.bvalid), 32'h1);
        wr_resp_ready = 1'b1;
        for (int k = 9; k < 12; k++) begin
            while (wr_resp_valid !== 1'b1) tick();
            check(32'(wr_resp_id), 32'(k));
            check(32'(wr_resp_code), 32'(AXRS_RESP_OKAY));
            tick();
            wr_done_valid = 1'b0;
        end
        $display("test write response done");
    endtask

    // *********************************************
    // Run control
    // *********************************************
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Watchdog, far past the cycles the tests need
    initial begin
        #80000;
        fails++;
        tally_and_finish();
    end

    initial begin
        repeat (20) tick();
        rst_n = 1'b1;
        tick();
        t_idle();
        t_incr();
        t_wrap();
        t_b2b();
        t_stall();
        t_wresp();
        tally_and_finish();
    end
endmodule // tb
